// ---- exc_cause_params.svh ----
// Purpose: offsets, field positions and codes for the exception cause detector
// Assumes: included by bare name wherever the constants are needed
// Notes:   definitions only
`ifndef EXC_CAUSE_PARAMS_SVH
`define EXC_CAUSE_PARAMS_SVH

`define EXC_VEC_W          20
`define EXC_VEC_PROGRAM    20'h00700
`define EXC_VEC_FP_UNAVAIL 20'h00800
`define EXC_VEC_COUNTDOWN  20'h00900
`define EXC_VEC_IO_ERROR   20'h00a00
`define EXC_VEC_NONE       20'h00000

`define EXC_ADDR_W         32
`define EXC_STAT_W         32
`define EXC_STAT_RESET     32'h00000000
`define EXC_ADDR_RESET     32'h00000000
`define EXC_STAT_FP_EN     11
`define EXC_STAT_ILLEGAL   12
`define EXC_STAT_PRIV      13
`define EXC_STAT_TRAP      14

`define EXC_SPR_W          10
`define EXC_SPR_MSB        9
`define EXC_TRAP_W         5
`define EXC_REPLY_W        4
`define EXC_REPLY_IO_FAIL  4'h9

`endif

// ---- exc_cause_pkg.sv ----
// Purpose: types shared by the exception cause detector
// Assumes: exc_cause_params.svh
// Notes:   widths come from the header
`default_nettype none
`include "exc_cause_params.svh"

package exc_cause_pkg;

    typedef struct packed {
        logic                    valid;
        logic [`EXC_ADDR_W-1:0]  pc;
        logic                    illegal_op;
        logic                    privileged_op;
        logic                    spr_move;
        logic                    spr_invalid;
        logic [`EXC_SPR_W-1:0]   special_register_field;
        logic                    trap_instr;
        logic [`EXC_TRAP_W-1:0]  trap_sel;
        logic [`EXC_TRAP_W-1:0]  trap_cmp;
        logic                    fp_instr;
        logic                    fp_enabled_exc;
        logic                    mtfpscr_en_exc;
    } instr_info_t;

    typedef struct packed {
        logic fp_exc_mode_bit0;
        logic fp_exc_mode_bit1;
        logic user_privilege_bit;
        logic float_available_bit;
        logic external_int_enable;
    } machine_state_t;

    typedef struct packed {
        logic                    valid;
        logic [`EXC_REPLY_W-1:0] code;
        logic                    io_seg_mem;
        logic [`EXC_ADDR_W-1:0]  pc;
        logic [`EXC_ADDR_W-1:0]  next_pc;
    } bus_reply_t;

    typedef enum {
        CLS_NONE,
        CLS_IO_ERROR,
        CLS_ILLEGAL,
        CLS_PRIV,
        CLS_FP_UNAVAIL,
        CLS_FP_ENABLED,
        CLS_TRAP,
        CLS_COUNTDOWN
    } exc_class_t;

endpackage : exc_cause_pkg

`default_nettype wire

// ---- fp_summary_flag.sv ----
// Purpose: sticky fp enabled-exception summary bit
// Assumes: synchronous active-low reset
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none

module fp_summary_flag (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // events
    input  wire logic i_set,
    input  wire logic i_clear,
    // flag
    output logic      o_fp_enabled_exc_summary
);

    logic summary_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            summary_ff <= 1'b0;
        end else if (i_set) begin
            summary_ff <= 1'b1;
        end else if (i_clear) begin
            summary_ff <= 1'b0;
        end
    end

    assign o_fp_enabled_exc_summary = summary_ff;

    sum_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_set |=> summary_ff)
        else $error("summary bit not set after fp exception event");

endmodule : fp_summary_flag

`default_nettype wire

// ---- exc_cause_detect.sv ----
// Purpose: detect program, fp unavailable, countdown and io error exceptions
// Assumes: inputs synchronous to i_clk; one retiring instruction per cycle
// Notes:   outputs update one edge after the causing inputs
`timescale 1ns/1ps
`default_nettype none
`include "exc_cause_params.svh"

module exc_cause_detect
    import exc_cause_pkg::*;
#(
    parameter logic [`EXC_REPLY_W-1:0] IO_FAIL_CODE = `EXC_REPLY_IO_FAIL
) (
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    // instruction and state
    input  wire instr_info_t            i_instr,
    input  wire machine_state_t         i_machine_state_reg,
    input  wire logic                   i_fex_clear,
    input  wire logic [`EXC_ADDR_W-1:0] i_resume_pc,
    // countdown register and bus reply
    input  wire logic [`EXC_ADDR_W-1:0] i_countdown_register,
    input  wire bus_reply_t             i_reply,
    // exception outputs
    output logic                        o_fetch_redirect,
    output logic [`EXC_VEC_W-1:0]       o_fetch_vector,
    output logic [`EXC_ADDR_W-1:0]      o_save_restore_address,
    output logic [`EXC_STAT_W-1:0]      o_save_restore_status,
    output logic                        o_fp_enabled_exc_summary
);

    logic                   cd_msb_ff;
    logic                   cd_pend_ff;
    logic                   redirect_ff;
    logic [`EXC_VEC_W-1:0]  vector_ff;
    logic [`EXC_ADDR_W-1:0] sra_ff;
    logic [`EXC_STAT_W-1:0] srs_ff;
    logic                   fp_enabled_exc_summary;
    logic                   fex_set;
    logic                   io_fail;
    logic                   ill;
    logic                   priv;
    logic                   fp_unav;
    logic                   fp_en;
    logic                   trap;
    logic                   cd_edge;
    logic                   cd_take;
    exc_class_t             cls;

    function automatic logic [`EXC_VEC_W-1:0] class_vector(input exc_class_t c);
        unique case (c)
            CLS_IO_ERROR:   class_vector = `EXC_VEC_IO_ERROR;
            CLS_ILLEGAL,
            CLS_PRIV,
            CLS_FP_ENABLED,
            CLS_TRAP:       class_vector = `EXC_VEC_PROGRAM;
            CLS_FP_UNAVAIL: class_vector = `EXC_VEC_FP_UNAVAIL;
            CLS_COUNTDOWN:  class_vector = `EXC_VEC_COUNTDOWN;
            CLS_NONE:       class_vector = `EXC_VEC_NONE;
        endcase
    endfunction : class_vector

    // fp work only counts when the unit is available
    assign fex_set = i_instr.valid && i_instr.fp_instr
                   && i_machine_state_reg.float_available_bit
                   && (i_instr.fp_enabled_exc || i_instr.mtfpscr_en_exc);

    fp_summary_flag u_fp_summary (
        .i_clk                    (i_clk),
        .i_rst_n                  (i_rst_n),
        .i_set                    (fex_set),
        .i_clear                  (i_fex_clear),
        .o_fp_enabled_exc_summary (fp_enabled_exc_summary)
    );

    assign io_fail = i_reply.valid && (i_reply.code == IO_FAIL_CODE);

    assign ill = i_instr.valid && (i_instr.illegal_op
               || (i_instr.spr_move && i_instr.spr_invalid
                   && !(i_instr.special_register_field[`EXC_SPR_MSB]
                        && i_machine_state_reg.user_privilege_bit)));

    assign priv = i_instr.valid && i_machine_state_reg.user_privilege_bit
                && (i_instr.privileged_op
                    || (i_instr.spr_move && i_instr.spr_invalid
                        && i_instr.special_register_field[`EXC_SPR_MSB]));

    assign fp_unav = i_instr.valid && i_instr.fp_instr
                   && !i_machine_state_reg.float_available_bit;

    // taken on the same instruction, but only when fp_exc_mode_bit0 or fp_exc_mode_bit1 is set
    assign fp_en = i_instr.valid
                 && (i_machine_state_reg.fp_exc_mode_bit0
                     || i_machine_state_reg.fp_exc_mode_bit1)
                 && (fp_enabled_exc_summary || fex_set);

    assign trap = i_instr.valid && i_instr.trap_instr
                && |(i_instr.trap_sel & i_instr.trap_cmp);

    assign cd_edge = !cd_msb_ff && i_countdown_register[`EXC_ADDR_W-1];
    assign cd_take = (cd_pend_ff || cd_edge)
                   && i_machine_state_reg.external_int_enable;

    always_comb begin
        if (io_fail)       cls = CLS_IO_ERROR;
        else if (ill)      cls = CLS_ILLEGAL;
        else if (priv)     cls = CLS_PRIV;
        else if (fp_unav)  cls = CLS_FP_UNAVAIL;
        else if (fp_en)    cls = CLS_FP_ENABLED;
        else if (trap)     cls = CLS_TRAP;
        else if (cd_take)  cls = CLS_COUNTDOWN;
        else               cls = CLS_NONE;
    end

    // countdown edge history and pending flag
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cd_msb_ff <= 1'b0;
        end else begin
            cd_msb_ff <= i_countdown_register[`EXC_ADDR_W-1];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cd_pend_ff <= 1'b0;
        end else if (cls == CLS_COUNTDOWN) begin
            cd_pend_ff <= 1'b0;
        end else if (cd_edge) begin
            cd_pend_ff <= 1'b1;
        end
    end

    // redirect and save registers move on the same edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            redirect_ff <= 1'b0;
            vector_ff   <= `EXC_VEC_NONE;
        end else begin
            redirect_ff <= (cls != CLS_NONE);
            vector_ff   <= class_vector(cls);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sra_ff <= `EXC_ADDR_RESET;
        end else begin
            unique case (cls)
                CLS_IO_ERROR:  sra_ff <= i_reply.io_seg_mem ? i_reply.next_pc
                                                            : i_reply.pc;
                CLS_COUNTDOWN: sra_ff <= i_resume_pc;
                CLS_NONE:      sra_ff <= sra_ff;
                default:       sra_ff <= i_instr.pc;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            srs_ff <= `EXC_STAT_RESET;
        end else if (cls != CLS_NONE) begin
            srs_ff                    <= `EXC_STAT_RESET;
            srs_ff[`EXC_STAT_ILLEGAL] <= (cls == CLS_ILLEGAL);
            srs_ff[`EXC_STAT_PRIV]    <= (cls == CLS_PRIV);
            srs_ff[`EXC_STAT_FP_EN]   <= (cls == CLS_FP_ENABLED);
            srs_ff[`EXC_STAT_TRAP]    <= (cls == CLS_TRAP);
        end
    end

    assign o_fetch_redirect         = redirect_ff;
    assign o_fetch_vector           = vector_ff;
    assign o_save_restore_address   = sra_ff;
    assign o_save_restore_status    = srs_ff;
    assign o_fp_enabled_exc_summary = fp_enabled_exc_summary;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    prog_vector_a: assert property ((ill || priv) && !io_fail
        |=> o_fetch_redirect && o_fetch_vector == `EXC_VEC_PROGRAM)
        else $error("program cause did not vector to program offset");
    fp_enabled_a: assert property (fp_en && !io_fail && !ill && !priv && !fp_unav
        |=> o_save_restore_status[`EXC_STAT_FP_EN])
        else $error("fp enabled cause not recorded");
    illegal_bit_a: assert property (ill && !io_fail
        |=> o_save_restore_status[`EXC_STAT_ILLEGAL] && !o_save_restore_status[`EXC_STAT_PRIV])
        else $error("illegal cause not recorded alone");
    priv_bit_a: assert property (priv && !io_fail && !ill
        |=> o_save_restore_status[`EXC_STAT_PRIV])
        else $error("privileged cause not recorded");
    spr_priv_a: assert property (i_instr.valid && i_instr.spr_move && i_instr.spr_invalid
        && i_instr.special_register_field[`EXC_SPR_MSB]
        && i_machine_state_reg.user_privilege_bit && !io_fail && !i_instr.illegal_op
        |=> o_save_restore_status[`EXC_STAT_PRIV])
        else $error("user move of invalid special register not privileged");
    trap_bit_a: assert property (cls == CLS_TRAP
        |=> o_save_restore_status[`EXC_STAT_TRAP] && o_save_restore_address == $past(i_instr.pc))
        else $error("trap not recorded with instruction address");
    fp_unavail_a: assert property (fp_unav && !io_fail && !ill && !priv
        |=> o_fetch_vector == `EXC_VEC_FP_UNAVAIL)
        else $error("fp unavailable did not vector");
    cd_gate_a: assert property (!i_machine_state_reg.external_int_enable
        && !io_fail && !ill && !priv && !fp_unav && !fp_en && !trap
        |=> !o_fetch_redirect)
        else $error("countdown taken with external enable clear");
    cd_edge_a: assert property ($rose(i_countdown_register[`EXC_ADDR_W-1])
        && i_machine_state_reg.external_int_enable ##0 !io_fail && !i_instr.valid
        |=> o_fetch_redirect && o_fetch_vector == `EXC_VEC_COUNTDOWN)
        else $error("countdown edge not taken");
    io_next_a: assert property (io_fail && i_reply.io_seg_mem
        |=> o_fetch_vector == `EXC_VEC_IO_ERROR
            && o_save_restore_address == $past(i_reply.next_pc))
        else $error("io error vector or saved address wrong");
    redirect_only_a: assert property (o_fetch_redirect |-> o_fetch_vector != `EXC_VEC_NONE)
        else $error("redirect without vector");
    prog_onehot_a: assert property (o_fetch_redirect
        |-> (o_fetch_vector == `EXC_VEC_PROGRAM) ? $onehot(o_save_restore_status)
                                                 : (o_save_restore_status == `EXC_STAT_RESET))
        else $error("save status does not hold exactly the program cause");

    cov_trap_c:  cover property (cls == CLS_TRAP ##1 o_fetch_redirect);
    cov_cd_c:    cover property (cd_edge ##[1:20] o_fetch_vector == `EXC_VEC_COUNTDOWN);
    cov_io_c:    cover property (io_fail && i_reply.io_seg_mem);
    cov_fpen_c:  cover property (fex_set ##[1:4] cls == CLS_FP_ENABLED);

endmodule : exc_cause_detect

`default_nettype wire

// ---- exc_cause_detect_tb_top.sv ----
// Purpose: self-checking bench for the exception cause detector
// Assumes: inputs change at the falling edge; outputs follow one rising edge later
// Notes:   each scenario task drives and judges its own traffic; no random stimulus
`timescale 1ns/1ps
`default_nettype none
`include "exc_cause_params.svh"

module exc_cause_detect_tb_top;
    import exc_cause_pkg::*;

    logic                   clk;
    logic                   rst_n;
    instr_info_t            instr;
    machine_state_t         machine_state_reg;
    logic                   fex_clear;
    logic [`EXC_ADDR_W-1:0] resume_pc;
    logic [`EXC_ADDR_W-1:0] countdown;
    bus_reply_t             reply;
    logic                   redirect;
    logic [`EXC_VEC_W-1:0]  vector;
    logic [`EXC_ADDR_W-1:0] sr_addr;
    logic [`EXC_STAT_W-1:0] sr_stat;
    logic                   summary;
    int                     num_errors;
    int                     comparisons;
    int                     cycles;

    exc_cause_detect #(
        .IO_FAIL_CODE(`EXC_REPLY_IO_FAIL)
    ) exc_cause_detect_inst (
        .i_clk                    (clk),
        .i_rst_n                  (rst_n),
        .i_instr                  (instr),
        .i_machine_state_reg      (machine_state_reg),
        .i_fex_clear              (fex_clear),
        .i_resume_pc              (resume_pc),
        .i_countdown_register     (countdown),
        .i_reply                  (reply),
        .o_fetch_redirect         (redirect),
        .o_fetch_vector           (vector),
        .o_save_restore_address   (sr_addr),
        .o_save_restore_status    (sr_stat),
        .o_fp_enabled_exc_summary (summary)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // the whole run needs about fifty cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic instr_info_t op(input logic [31:0] pc);
        op = '0;
        op.valid = 1'b1;
        op.pc = pc;
    endfunction : op

    // present one cycle of stimulus, return where its answer is visible
    task automatic fire(input instr_info_t ins, input bus_reply_t rep);
        instr = ins;
        reply = rep;
        @(negedge clk);
        instr = '0;
        reply = '0;
    endtask : fire

    task automatic expect_exc(input logic [19:0] vec, input logic [31:0] addr,
                              input logic [31:0] stat);
        check("redirect", 32'(redirect), 32'h1);
        check("vector", 32'(vector), 32'(vec));
        check("address", sr_addr, addr);
        check("status", sr_stat, stat);
        @(negedge clk);
        check("redirect drop", 32'(redirect), 32'h0);
    endtask : expect_exc

    task automatic expect_none();
        check("no redirect", 32'(redirect), 32'h0);
        @(negedge clk);
    endtask : expect_none

    task automatic t_trap();
        instr_info_t ins;
        ins = op(32'h0000_1000);
        ins.trap_instr = 1'b1;
        ins.trap_sel = 5'h04;
        ins.trap_cmp = 5'h04;
        fire(ins, '0);
        expect_exc(`EXC_VEC_PROGRAM, 32'h0000_1000, 32'h1 << `EXC_STAT_TRAP);
        ins.trap_cmp = 5'h1b;
        fire(ins, '0);
        expect_none();
    endtask : t_trap

    task automatic t_priv();
        instr_info_t ins;
        ins = op(32'h0000_2000);
        ins.illegal_op = 1'b1;
        fire(ins, '0);
        expect_exc(`EXC_VEC_PROGRAM, 32'h0000_2000, 32'h1 << `EXC_STAT_ILLEGAL);
        ins = op(32'h0000_2004);
        ins.privileged_op = 1'b1;
        fire(ins, '0);
        expect_none();
        machine_state_reg.user_privilege_bit = 1'b1;
        fire(ins, '0);
        expect_exc(`EXC_VEC_PROGRAM, 32'h0000_2004, 32'h1 << `EXC_STAT_PRIV);
        ins = op(32'h0000_2008);
        ins.spr_move = 1'b1;
        ins.spr_invalid = 1'b1;
        ins.special_register_field = 10'h200;
        fire(ins, '0);
        expect_exc(`EXC_VEC_PROGRAM, 32'h0000_2008, 32'h1 << `EXC_STAT_PRIV);
        ins.special_register_field = 10'h001;
        fire(ins, '0);
        expect_exc(`EXC_VEC_PROGRAM, 32'h0000_2008, 32'h1 << `EXC_STAT_ILLEGAL);
        machine_state_reg.user_privilege_bit = 1'b0;
    endtask : t_priv

    task automatic clear_summary();
        fex_clear = 1'b1;
        @(negedge clk);
        fex_clear = 1'b0;
        check("summary cleared", 32'(summary), 32'h0);
    endtask : clear_summary

    task automatic t_fp();
        instr_info_t ins;
        machine_state_reg.float_available_bit = 1'b0;
        ins = op(32'h0000_3000);
        ins.fp_instr = 1'b1;
        fire(ins, '0);
        expect_exc(`EXC_VEC_FP_UNAVAIL, 32'h0000_3000, 32'h0);
        machine_state_reg.float_available_bit = 1'b1;
        ins = op(32'h0000_3004);
        ins.fp_instr = 1'b1;
        ins.fp_enabled_exc = 1'b1;
        fire(ins, '0);
        expect_none();
        check("summary set", 32'(summary), 32'h1);
        machine_state_reg.fp_exc_mode_bit0 = 1'b1;
        fire(op(32'h0000_3008), '0);
        expect_exc(`EXC_VEC_PROGRAM, 32'h0000_3008, 32'h1 << `EXC_STAT_FP_EN);
        machine_state_reg.fp_exc_mode_bit0 = 1'b0;
        clear_summary();
        ins = op(32'h0000_300c);
        ins.fp_instr = 1'b1;
        ins.mtfpscr_en_exc = 1'b1;
        fire(ins, '0);
        expect_none();
        check("summary move", 32'(summary), 32'h1);
        machine_state_reg.fp_exc_mode_bit1 = 1'b1;
        fire(op(32'h0000_3010), '0);
        expect_exc(`EXC_VEC_PROGRAM, 32'h0000_3010, 32'h1 << `EXC_STAT_FP_EN);
        machine_state_reg.fp_exc_mode_bit1 = 1'b0;
        clear_summary();
    endtask : t_fp

    task automatic t_countdown();
        resume_pc = 32'h0000_4000;
        countdown = 32'h8000_0000;
        repeat (3) begin
            @(negedge clk);
            expect_none();
        end
        machine_state_reg.external_int_enable = 1'b1;
        @(negedge clk);
        expect_exc(`EXC_VEC_COUNTDOWN, 32'h0000_4000, 32'h0);
        countdown = 32'h7fff_ffff;
        @(negedge clk);
        countdown = 32'h8000_0000;
        resume_pc = 32'h0000_4100;
        @(negedge clk);
        expect_exc(`EXC_VEC_COUNTDOWN, 32'h0000_4100, 32'h0);
        countdown = 32'h0;
        machine_state_reg.external_int_enable = 1'b0;
    endtask : t_countdown

    task automatic t_io();
        instr_info_t ins;
        bus_reply_t  rep;
        rep = '0;
        rep.valid = 1'b1;
        rep.code = `EXC_REPLY_IO_FAIL;
        rep.io_seg_mem = 1'b1;
        rep.pc = 32'h0000_5000;
        rep.next_pc = 32'h0000_5004;
        ins = op(32'h0000_5010);
        ins.illegal_op = 1'b1;
        fire(ins, rep);
        expect_exc(`EXC_VEC_IO_ERROR, 32'h0000_5004, 32'h0);
        rep.code = 4'h3;
        fire('0, rep);
        expect_none();
        rep.code = `EXC_REPLY_IO_FAIL;
        rep.io_seg_mem = 1'b0;
        fire('0, rep);
        expect_exc(`EXC_VEC_IO_ERROR, 32'h0000_5000, 32'h0);
    endtask : t_io

    initial begin
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        rst_n = 1'b0;
        instr = '0;
        reply = '0;
        fex_clear = 1'b0;
        resume_pc = 32'h0;
        countdown = 32'h0;
        machine_state_reg = '0;
        machine_state_reg.float_available_bit = 1'b1;
        repeat (6) @(negedge clk);
        check("reset redirect", 32'(redirect), 32'h0);
        check("reset status", sr_stat, `EXC_STAT_RESET);
        check("reset summary", 32'(summary), 32'h0);
        rst_n = 1'b1;
        @(negedge clk);
        t_trap();
        t_priv();
        t_fp();
        t_countdown();
        t_io();
        final_report();
    end

endmodule : exc_cause_detect_tb_top

`default_nettype wire
